/* File: hdl/dtc_pkg.sv */
// Constants and types shared by the dual timer/counter unit.
// How it works
// - Timer function counts every twelve-clock machine cycle.
// - Counter samples pin once per cycle, counts falling.
// - Counted edge appears at next cycle's update phase.
// - Counter accepts events at most clock/24.
// - Function bit and two-bit mode chosen per timer.
// - Mode 0 counts thirteen bits, high plus low five.
// - Rollover to zero sets the timer's overflow flag.
// - Count when run set and gate allows; in split, high byte skips gate, timer one skips run.
// - Starting a timer never clears its count.
// - Gate bits are mode bit 7 and 3.
// - Mode 1 counts sixteen bits, flags wrap, continues.
// - Mode 2 reloads low byte from high byte.
// - Timer one in mode 3 holds its count.
// - Split mode low byte uses timer zero controls.
// - Split high byte times, uses timer one run/flag.
// - Split timer zero lets timer one run flagless.
package dtc_pkg;

	// Machine cycle of twelve clocks, numbered 0 to 11 as S1P1 .. S6P2.
	localparam int          MC_CLOCKS    = 12;
	localparam logic [3:0]  PH_LAST      = 4'(MC_CLOCKS - 1);
	localparam logic [3:0]  PH_SAMPLE    = 4'h9;
	localparam logic [3:0]  PH_UPDATE    = 4'h4;

	// Operating modes.
	localparam logic [1:0]  MODE_13BIT   = 2'h0;
	localparam logic [1:0]  MODE_16BIT   = 2'h1;
	localparam logic [1:0]  MODE_RELOAD  = 2'h2;
	localparam logic [1:0]  MODE_SPLIT   = 2'h3;

	// Byte offsets of the registers on the APB slave.
	localparam logic [7:0]  OFS_MODE     = 8'h00;
	localparam logic [7:0]  OFS_CTRL     = 8'h04;
	localparam logic [7:0]  OFS_LOW0     = 8'h08;
	localparam logic [7:0]  OFS_HIGH0    = 8'h0c;
	localparam logic [7:0]  OFS_LOW1     = 8'h10;
	localparam logic [7:0]  OFS_HIGH1    = 8'h14;
	localparam logic [7:0]  OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0]  OFS_IRQ_MASK = 8'h1c;

	// Mode register fields.
	localparam int          MB_GATE1     = 7;
	localparam int          MB_FUNC1     = 6;
	localparam int          MB_MODE1     = 4;
	localparam int          MB_GATE0     = 3;
	localparam int          MB_FUNC0     = 2;
	localparam int          MB_MODE0     = 0;

	// Control register fields.
	localparam int          CB_OVF1      = 7;
	localparam int          CB_RUN1      = 6;
	localparam int          CB_OVF0      = 5;
	localparam int          CB_RUN0      = 4;

	// Interrupt status and mask fields.
	localparam int          IB_OVF0      = 0;
	localparam int          IB_OVF1      = 1;

	// Reset values.
	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [1:0]  RST_IRQ      = 2'h0;

endpackage

/* File: hdl/dtc_sync.sv */
// Two-stage synchroniser for asynchronous input pins.
`timescale 1ns/1ns
module dtc_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         i_sys_clk,
	input  wire logic         i_nrst,
	// Asynchronous input and synchronised output.
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} dtc_sync_state_t;

	dtc_sync_state_t q_reg;
	dtc_sync_state_t q_next;

	// The first stage feeds only the second, so a metastable value never spreads.
	always_comb
	begin
		q_next        = q_reg;
		q_next.meta   = i_async;
		q_next.stable = q_reg.meta;
	end

	// State register.
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			q_reg <= '0;
		else
			q_reg <= q_next;
	end

	assign o_sync = q_reg.stable;

endmodule

/* File: hdl/dtc_top.sv */
// Dual 16-bit timer/counter unit with an APB register slave.
`timescale 1ns/1ns
module dtc_top (
	// Clock and reset.
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	// APB slave.
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// External pins.
	input  wire logic        i_event_input_zero,
	input  wire logic        i_event_input_one,
	input  wire logic        i_gate_pin_zero,
	input  wire logic        i_gate_pin_one,
	// Interrupt and baud tick.
	output logic             o_irq,
	output logic             o_baud_tick
);
	import dtc_pkg::*;

	// All state lives in one packed struct. The phase field walks the
	// twelve clocks of a machine cycle; smp and pend hold the last pin
	// sample and an edge still waiting for its update phase. The APB
	// answer fields are kept here too so every output leaves a flip-flop.
	typedef struct packed {
		logic [3:0]  phase;
		logic [7:0]  timer_mode_register;
		logic        run_bit_timer_zero;
		logic        run_bit_timer_one;
		logic        overflow_flag_timer_zero;
		logic        overflow_flag_timer_one;
		logic [7:0]  count_low_byte_zero;
		logic [7:0]  count_high_byte_zero;
		logic [7:0]  count_low_byte_one;
		logic [7:0]  count_high_byte_one;
		logic        smp0;
		logic        smp1;
		logic        pend0;
		logic        pend1;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_mask;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
		logic        baud_tick;
	} dtc_state_t;

	dtc_state_t q_reg;
	dtc_state_t q_next;

	// Synchronised pin levels, one bit per pin.
	logic [3:0] pins_sync;
	logic       ev0;
	logic       ev1;
	logic       gp0;
	logic       gp1;

	// The sync adds two clocks of latency to every pin; an edge in the two clocks
	// before the sample phase is therefore seen one machine cycle later.
	// Every pin is asynchronous, so all four pass the two-stage synchroniser.
	dtc_sync #(
		.W (4)
	) u_pin_sync (
		.i_sys_clk (i_sys_clk),
		.i_nrst    (i_nrst),
		.i_async   ({i_gate_pin_one, i_gate_pin_zero, i_event_input_one, i_event_input_zero}),
		.o_sync    (pins_sync)
	);

	assign ev0 = pins_sync[0];
	assign ev1 = pins_sync[1];
	assign gp0 = pins_sync[2];
	assign gp1 = pins_sync[3];

	// The step function keeps the counting arithmetic in one place so that
	// both timers share exactly the same behaviour in modes 0 to 2. Bit 16 of the
	// result is the rollover, which the caller turns into a flag.
	// In thirteen-bit mode the carry leaves the fifth low bit straight into
	// the high byte; the three upper low bits are passed through untouched
	// because software must ignore them anyway.
	// One count step: returns {overflow, high, low} for the given mode.
	function automatic logic [16:0] dtc_step(
		input logic [1:0] m,
		input logic [7:0] l,
		input logic [7:0] h
	);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0]  s8;
		logic [16:0] r;
		s13 = {1'b0, h, l[4:0]} + 14'h0001;
		s16 = {1'b0, h, l} + 17'h00001;
		s8  = {1'b0, l} + 9'h001;
		case (m)
			MODE_13BIT:
				r = {s13[13], s13[12:5], l[7:5], s13[4:0]};
			MODE_16BIT:
				r = s16;
			MODE_RELOAD:
				r = s8[8] ? {1'b1, h, h} : {1'b0, h, s8[7:0]};
			default:
				r = {s8[8], h, s8[7:0]};
		endcase
		return r;
	endfunction

	// Only the eight word offsets below answer without an error; any other
	// address reads as zero and a write to it is dropped.
	// Address decode for the APB slave.
	function automatic logic dtc_mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		case (a)
			OFS_MODE, OFS_CTRL, OFS_LOW0, OFS_HIGH0,
			OFS_LOW1, OFS_HIGH1, OFS_IRQ_STAT, OFS_IRQ_MASK:
				hit = 1'b1;
			default:
				hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Next-state logic: phase sequencer, edge detect, counting, APB, flags.
	always_comb
	begin
		logic [1:0]  mode0;
		logic [1:0]  mode1;
		logic        split0;
		logic        tick0;
		logic        tick1;
		logic        en0;
		logic        en1;
		logic [16:0] st0;
		logic [16:0] st1;
		logic [8:0]  hs;
		logic        ovf0_ev;
		logic        ovf1_ev;
		logic        acc;
		logic        wr;
		logic [7:0]  wd;
		logic [7:0]  rd;
		mode0   = q_reg.timer_mode_register[MB_MODE0 +: 2];
		mode1   = q_reg.timer_mode_register[MB_MODE1 +: 2];
		split0  = (mode0 == MODE_SPLIT);
		tick0   = 1'b0;
		tick1   = 1'b0;
		en0     = 1'b0;
		en1     = 1'b0;
		st0     = '0;
		st1     = '0;
		hs      = '0;
		ovf0_ev = 1'b0;
		ovf1_ev = 1'b0;
		acc     = i_psel & i_penable;
		wr      = acc & q_reg.pready & i_pwrite & dtc_mapped(i_paddr);
		wd      = i_pwdata[7:0];
		rd      = 8'h00;

		q_next           = q_reg;
		q_next.pready    = 1'b0;
		q_next.pslverr   = 1'b0;
		q_next.baud_tick = 1'b0;

		// The phase counter is free running from reset, so the first machine
		// cycle after reset is a full one and the first update comes at phase 4.
		// Machine cycle sequencer of twelve clocks.
		q_next.phase = (q_reg.phase == PH_LAST) ? 4'h0 : q_reg.phase + 4'h1;

		// Pins are sampled once per machine cycle; a high then low pair marks an edge.
		// One sample per cycle and a two-cycle detect caps the event rate at clock/24.
		// The pending bit waits for the next update phase.
		if (q_reg.phase == PH_SAMPLE)
		begin
			if (q_reg.smp0 && !ev0)
				q_next.pend0 = 1'b1;
			if (q_reg.smp1 && !ev1)
				q_next.pend1 = 1'b1;
			q_next.smp0 = ev0;
			q_next.smp1 = ev1;
		end

		// All counts move at the update phase, the cycle after the edge was seen.
		if (q_reg.phase == PH_UPDATE)
		begin
			q_next.pend0 = 1'b0;
			q_next.pend1 = 1'b0;
			tick0 = q_reg.timer_mode_register[MB_FUNC0] ? q_reg.pend0 : 1'b1;
			tick1 = q_reg.timer_mode_register[MB_FUNC1] ? q_reg.pend1 : 1'b1;
			en0 = q_reg.run_bit_timer_zero
				& (!q_reg.timer_mode_register[MB_GATE0] | gp0);
			// With timer zero split, timer one loses its run bit and runs by mode.
			if (split0)
				en1 = !q_reg.timer_mode_register[MB_GATE1] | gp1;
			else
				en1 = q_reg.run_bit_timer_one
					& (!q_reg.timer_mode_register[MB_GATE1] | gp1);

			// Timer zero; counts are never cleared by starting.
			if (en0 && tick0)
			begin
				st0 = dtc_step(mode0, q_reg.count_low_byte_zero, q_reg.count_high_byte_zero);
				q_next.count_low_byte_zero = st0[7:0];
				if (!split0)
					q_next.count_high_byte_zero = st0[15:8];
				ovf0_ev = st0[16];
			end

			// The split high byte ignores both gate bits: it is a pure machine
			// cycle timer.
			// Split high byte: machine cycle timer owned by timer one's run bit.
			if (split0 && q_reg.run_bit_timer_one)
			begin
				hs = {1'b0, q_reg.count_high_byte_zero} + 9'h001;
				q_next.count_high_byte_zero = hs[7:0];
				ovf1_ev = hs[8];
			end

			// Timer one still produces its baud tick while timer zero is split.
			// Timer one in its own mode 3 simply holds.
			if (en1 && tick1 && mode1 != MODE_SPLIT)
			begin
				st1 = dtc_step(mode1, q_reg.count_low_byte_one, q_reg.count_high_byte_one);
				q_next.count_low_byte_one  = st1[7:0];
				q_next.count_high_byte_one = st1[15:8];
				q_next.baud_tick           = st1[16];
				if (!split0)
					ovf1_ev = st1[16];
			end
		end

		// The slave always inserts exactly one wait state: the first access edge
		// latches read data and the error bit, the second completes the transfer.
		// A master that drops penable early simply restarts the wait.
		// APB access phase: one wait state, data and error latched with pready.
		if (acc && !q_reg.pready)
		begin
			case (i_paddr)
				OFS_MODE:
					rd = q_reg.timer_mode_register;
				OFS_CTRL:
					rd = {q_reg.overflow_flag_timer_one, q_reg.run_bit_timer_one,
						q_reg.overflow_flag_timer_zero, q_reg.run_bit_timer_zero, 4'h0};
				OFS_LOW0:
					rd = q_reg.count_low_byte_zero;
				OFS_HIGH0:
					rd = q_reg.count_high_byte_zero;
				OFS_LOW1:
					rd = q_reg.count_low_byte_one;
				OFS_HIGH1:
					rd = q_reg.count_high_byte_one;
				OFS_IRQ_STAT:
					rd = {6'h00, q_reg.irq_stat};
				OFS_IRQ_MASK:
					rd = {6'h00, q_reg.irq_mask};
				default:
					rd = 8'h00;
			endcase
			q_next.pready  = 1'b1;
			q_next.prdata  = {24'h000000, rd};
			q_next.pslverr = !dtc_mapped(i_paddr);
		end

		// Only the low byte of the write data is used; the upper bits are ignored
		// rather than flagged, which keeps byte-wide drivers simple.
		// Writes land at the completing edge and win over a count in the same cycle.
		if (wr)
		begin
			case (i_paddr)
				OFS_MODE:
					q_next.timer_mode_register = wd;
				OFS_CTRL:
				begin
					q_next.run_bit_timer_zero       = wd[CB_RUN0];
					q_next.run_bit_timer_one        = wd[CB_RUN1];
					q_next.overflow_flag_timer_zero = wd[CB_OVF0];
					q_next.overflow_flag_timer_one  = wd[CB_OVF1];
				end
				OFS_LOW0:
					q_next.count_low_byte_zero = wd;
				OFS_HIGH0:
					q_next.count_high_byte_zero = wd;
				OFS_LOW1:
					q_next.count_low_byte_one = wd;
				OFS_HIGH1:
					q_next.count_high_byte_one = wd;
				OFS_IRQ_STAT:
					q_next.irq_stat = q_reg.irq_stat & ~wd[1:0];
				OFS_IRQ_MASK:
					q_next.irq_mask = wd[1:0];
				default:
					q_next.irq_mask = q_reg.irq_mask;
			endcase
		end

		// Hardware sets come last so an overflow beats a clear in the same cycle.
		if (ovf0_ev)
		begin
			q_next.overflow_flag_timer_zero = 1'b1;
			q_next.irq_stat[IB_OVF0]        = 1'b1;
		end
		if (ovf1_ev)
		begin
			q_next.overflow_flag_timer_one = 1'b1;
			q_next.irq_stat[IB_OVF1]       = 1'b1;
		end

		// The interrupt level is taken from the next state so that it rises at
		// the same edge as the flag, not one cycle later.
		q_next.irq = |(q_next.irq_stat & q_next.irq_mask);
	end

	// Reset clears the whole struct first; the named fields below repeat the
	// package reset values so a change of those constants is seen here.
	// State register; reset leaves every timer stopped at zero.
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			q_reg                          <= '0;
			q_reg.timer_mode_register      <= RST_BYTE;
			q_reg.count_low_byte_zero      <= RST_BYTE;
			q_reg.count_high_byte_zero     <= RST_BYTE;
			q_reg.count_low_byte_one       <= RST_BYTE;
			q_reg.count_high_byte_one      <= RST_BYTE;
			q_reg.irq_stat                 <= RST_IRQ;
			q_reg.irq_mask                 <= RST_IRQ;
		end
		else
			q_reg <= q_next;
	end

	// No output is decoded combinationally, so the bus and the interrupt line
	// never glitch while the state settles.
	// Outputs straight from the state register.
	assign o_prdata    = q_reg.prdata;
	assign o_pready    = q_reg.pready;
	assign o_pslverr   = q_reg.pslverr;
	assign o_irq       = q_reg.irq;
	assign o_baud_tick = q_reg.baud_tick;

endmodule

/* File: sim/dtc_src.sv */
// Event pin source that drives one counter input.
`timescale 1ns/1ns
module dtc_src (
	// Clock and request.
	input  wire logic       i_sys_clk,
	input  wire logic       i_go,
	input  wire logic [3:0] i_cnt,
	input  wire logic       i_slow,
	// Pin and status.
	output logic            o_pin,
	output logic            o_busy
);
	// Levels last one or two machine cycles, so no level goes unsampled.
	initial
	begin
		o_pin = 1'b1;
		o_busy = 1'b0;
		forever
		begin
			@(posedge i_sys_clk);
			if (i_go)
			begin
				o_busy <= 1'b1;
				repeat (i_cnt)
				begin
					o_pin <= 1'b0;
					repeat (i_slow ? 24 : 12) @(posedge i_sys_clk);
					o_pin <= 1'b1;
					repeat (i_slow ? 24 : 12) @(posedge i_sys_clk);
				end
				o_busy <= 1'b0;
			end
		end
	end
endmodule

/* File: sim/dtc_chk.sv */
// Port assertions for the dual timer unit.
`timescale 1ns/1ns
module dtc_chk (
	// Clock and reset.
	input wire logic        i_sys_clk,
	input wire logic        i_nrst,
	// APB slave.
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	// Interrupt and tick.
	input wire logic        o_irq,
	input wire logic        o_baud_tick
);
	// One clock domain for every check.
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);
	// An access waits one cycle, then ready pulses once.
	sequence s_wait;
		!o_pready ##1 o_pready ##1 !o_pready;
	endsequence
	a_one_wait_state: assert property ($rose(i_penable) && i_psel |-> s_wait)
		else $error("ready not after one wait");
	a_ready_in_access: assert property ($rose(o_pready) |-> $past(i_penable) && i_psel)
		else $error("ready outside access");
	a_error_with_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	a_unmapped_error: assert property (o_pready && i_paddr > 8'h1c |-> o_pslverr)
		else $error("no error on unmapped");
	a_rdata_on_ready: assert property ($changed(o_prdata) |-> o_pready)
		else $error("read data moved");
	a_rdata_upper_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_irq_falls_write: assert property ($fell(o_irq) |-> $past(o_pready) && $past(i_pwrite))
		else $error("irq fell without write");
	a_tick_spacing: assert property (
		o_baud_tick |=> !o_baud_tick [*8] ##1 !o_baud_tick [*3])
		else $error("ticks closer than a machine cycle");
	a_reset_quiet: assert property (
		$rose(i_nrst) |-> !o_irq && !o_pready && !o_baud_tick)
		else $error("outputs active after reset");
endmodule
bind dtc_top dtc_chk i_chk (
	.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_irq(o_irq), .o_baud_tick(o_baud_tick));

/* File: sim/dtc_tb.sv */
// Self-checking bench for the dual timer unit.
`timescale 1ns/1ns
module dtc_tb;
	import dtc_pkg::*;
	logic        clk, nrst, sel, en, wr, rdy, err, irq, tick, gerr, slow;
	logic [7:0]  adr;
	logic [31:0] wd, rd, got, prev;
	logic [1:0]  ev, gp, go, busy;
	logic [3:0]  np;
	int          err_total, n_checks, cyc, c0, rv;
	dtc_top i_dut (
		.i_sys_clk(clk), .i_nrst(nrst), .i_psel(sel), .i_penable(en),
		.i_pwrite(wr), .i_paddr(adr), .i_pwdata(wd), .o_prdata(rd),
		.o_pready(rdy), .o_pslverr(err), .i_event_input_zero(ev[0]),
		.i_event_input_one(ev[1]), .i_gate_pin_zero(gp[0]),
		.i_gate_pin_one(gp[1]), .o_irq(irq), .o_baud_tick(tick));
	dtc_src i_src0 (.i_sys_clk(clk), .i_go(go[0]), .i_cnt(np), .i_slow(slow),
		.o_pin(ev[0]), .o_busy(busy[0]));
	dtc_src i_src1 (.i_sys_clk(clk), .i_go(go[1]), .i_cnt(np), .i_slow(slow),
		.o_pin(ev[1]), .o_busy(busy[1]));
	// Clock of 50 ns.
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Hang guard, far past the few thousand cycles the run needs.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc > 30000)
		begin
			err_total++;
			stop_test();
		end
	end
	// Verdict.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Compares one value with the model.
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, s, x);
		end
	endtask
	// One APB transfer, held until ready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sel <= 1'b1;
		wr <= w;
		adr <= a;
		wd <= {24'h0, d};
		@(posedge clk);
		en <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1)
			@(posedge clk);
		got = rd;
		gerr = err;
		sel <= 1'b0;
		en <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 8'h00);
		chk(got, x);
		chk(gerr, 0);
	endtask
	// Main sequence.
	initial
	begin
		{sel, en, wr, adr, wd, gp, go, np, slow} = '0;
		nrst = 1'b0;
		void'($urandom(49));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++)
			rc(8'(4 * i), 0);
		apb(1'b0, 8'h20, 8'h00);
		chk(gerr, 1);
		chk(got, 0);
		apb(1'b1, OFS_IRQ_MASK, 8'h03);
		// Modes 0 to 2 of each timer overflow, then run two more cycles.
		for (int t = 0; t < 2; t++)
			for (int m = 0; m < 3; m++)
			begin
				rv = $urandom % 200;
				apb(1'b1, OFS_MODE, 8'(m << (4 * t)));
				apb(1'b1, t ? OFS_LOW1 : OFS_LOW0, 8'hff);
				apb(1'b1, t ? OFS_HIGH1 : OFS_HIGH0, m == 2 ? 8'(rv) : 8'hff);
				c0 = cyc;
				apb(1'b1, OFS_CTRL, t ? 8'h40 : 8'h10);
				@(posedge irq);
				#1 chk(tick, t);
				chk(cyc - c0 < 20, 1);
				rc(OFS_CTRL, t ? 8'hc0 : 8'h30);
				repeat (22) @(posedge clk);
				apb(1'b1, OFS_CTRL, 8'h00);
				apb(1'b0, t ? OFS_LOW1 : OFS_LOW0, 8'h00);
				chk(got & (m ? 32'hff : 32'h1f), m == 2 ? rv + 2 : 2);
				rc(t ? OFS_HIGH1 : OFS_HIGH0, m == 2 ? rv : 0);
				rc(OFS_IRQ_STAT, 1 << t);
				apb(1'b1, OFS_IRQ_MASK, 8'h00);
				#1 chk(irq, 0);
				apb(1'b1, OFS_IRQ_MASK, 8'h03);
				#1 chk(irq, 1);
				apb(1'b1, OFS_IRQ_STAT, 8'h03);
				#1 chk(irq, 0);
			end
		// Gated counters: edges lost while the gate is low, all counted when high.
		for (int t = 0; t < 2; t++)
		begin
			apb(1'b1, OFS_MODE, 8'(8'h0d << (4 * t)));
			apb(1'b1, t ? OFS_LOW1 : OFS_LOW0, 8'h00);
			apb(1'b1, OFS_CTRL, t ? 8'h40 : 8'h10);
			for (int g = 0; g < 2; g++)
			begin
				gp[t] <= g[0];
				np <= 4'($urandom % 6 + 1);
				slow <= 1'($urandom);
				go[t] <= 1'b1;
				@(posedge clk);
				go[t] <= 1'b0;
				@(posedge clk);
				while (busy[t])
					@(posedge clk);
				repeat (40) @(posedge clk);
				rc(t ? OFS_LOW1 : OFS_LOW0, g ? np : 0);
			end
		end
		// Split timer zero: its high byte uses timer one's run and flag.
		apb(1'b1, OFS_MODE, 8'h03);
		apb(1'b1, OFS_HIGH0, 8'hff);
		apb(1'b1, OFS_CTRL, 8'h40);
		@(posedge irq);
		rc(OFS_IRQ_STAT, 2);
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b1, OFS_MODE, k == 1 ? 8'h33 : 8'h03);
			apb(1'b0, OFS_LOW1, 8'h00);
			prev = got;
			repeat (32) @(posedge clk);
			apb(1'b0, OFS_LOW1, 8'h00);
			chk((got - prev) & 32'h1f, k == 1 ? 0 : 3);
		end
		stop_test();
	end
endmodule
